// ### rtm_chan_model.sv
// Purpose: Test channel model that feeds received idle status to the controller.
// Assumes: The channel locks on a bring-up pulse while the bench wants lock.
// Notes: Errors pass only while locked, as a real receiver reports them.
`timescale 1ns/10ps
`default_nettype none

module rtm_chan_model
	import rtm_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire rtm_ctl_t ctl_i,
	input wire logic want_lock_i,
	input wire logic err_i,
	output rtm_rx_t rx_o
);
	logic lock_r;

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			lock_r <= 1'b0;
		else if (!want_lock_i || !ctl_i.send_idle)
			lock_r <= 1'b0;
		else if (ctl_i.retrain)
			lock_r <= 1'b1;
	end

	assign rx_o = '{lock: lock_r, sym_err: lock_r & err_i};
endmodule // rtm_chan_model

`default_nettype wire

// ### rtm_ctrl.sv
// Purpose: Receiver test mode control, lock status and idle error counting.
// Assumes: All inputs but arst_n_i synchronous to ref_clk_i; receiver reports lock and errors.
// Notes: The test mode may also be switched on by a pin for parts without management.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

module rtm_ctrl
	import rtm_pkg::*;
#(
	parameter int RETRY_CYC = RETRY_CYCLES
)
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	input wire logic alt_test_en_i,
	input wire logic neg_follower_i,
	input wire rtm_rx_t rx_i,
	output rtm_ctl_t ctl_o,
	output logic test_active_o,
	output logic lock_o,
	output logic [ERRCNT_W-1:0] err_cnt_o,
	output logic irq_o
);

	localparam int RC_W = $clog2(RETRY_CYC + 1);
	localparam logic [RC_W-1:0] RC_RELOAD = RC_W'(RETRY_CYC - 1);
	localparam logic [RC_W-1:0] RC_ZERO = RC_W'(0);
	localparam logic [RC_W-1:0] RC_ONE = RC_W'(1);
	localparam int GAP_MAX = RETRY_CYC - 1;

	logic test_en_r;
	logic alt_en_r;
	logic active;
	rtm_state_t state_r;
	logic lock_r;
	logic [ERRCNT_W-1:0] err_cnt_r;
	logic [RC_W-1:0] retry_cnt_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_en_r;
	logic [IRQ_W-1:0] irq_set;
	logic [DATA_W-1:0] rdata_nxt;
	logic lock_up;
	logic lock_lost;
	logic cnt_sat;
	logic retrain_nxt;
	logic wr_role;

	// ------------------------------------------------------------------
	// Mode enable
	// ------------------------------------------------------------------
	assign wr_role = reg_wr_i && (reg_addr_i == REG_ROLE_CTRL);
	assign active = test_en_r || alt_en_r;

	// The enable bit changes only by an explicit write or reset, so only these or the pin falling with the bit clear drop the mode.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			test_en_r <= 1'b0;
		end
		else if (wr_role)
		begin
			test_en_r <= reg_wdata_i[BIT_TEST_EN];
		end
	end

	// The pin is a level held by the tester; it is registered so that it stays a clean level.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			alt_en_r <= 1'b0;
		end
		else
		begin
			alt_en_r <= alt_test_en_i;
		end
	end

	// ------------------------------------------------------------------
	// Receiver bring-up state machine
	// ------------------------------------------------------------------
	assign lock_up = active && (state_r == ST_ACQ) && rx_i.lock;
	assign lock_lost = active && (state_r == ST_LOCKED) && !rx_i.lock;
	assign cnt_sat = active && (state_r == ST_LOCKED) && rx_i.lock && rx_i.sym_err
		&& (err_cnt_r == (ERRCNT_MAX - ERRCNT_ONE));

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_r <= ST_OFF;
		end
		else if (!active)
		begin
			state_r <= ST_OFF;
		end
		else
		begin
			case (state_r)
				ST_OFF: state_r <= ST_ACQ;
				ST_ACQ:
					if (rx_i.lock)
					begin
						state_r <= ST_LOCKED;
					end
				ST_LOCKED:
					if (!rx_i.lock)
					begin
						state_r <= ST_ACQ;
					end
				default: state_r <= ST_OFF;
			endcase
		end
	end

	// Retries come on entry, on each loss and per interval, unlimited as settling may take long.
	assign retrain_nxt = (active && (state_r == ST_OFF)) || lock_lost
		|| (active && (state_r == ST_ACQ) && !rx_i.lock && (retry_cnt_r == RC_ZERO));

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			retry_cnt_r <= RC_ZERO;
		end
		else if (retrain_nxt || (state_r != ST_ACQ))
		begin
			retry_cnt_r <= RC_RELOAD;
		end
		else
		begin
			retry_cnt_r <= retry_cnt_r - RC_ONE;
		end
	end

	// ------------------------------------------------------------------
	// Lock status and error counter
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			lock_r <= 1'b0;
		end
		else if (!active || lock_lost)
		begin
			lock_r <= 1'b0;
		end
		else if (lock_up)
		begin
			lock_r <= 1'b1;
		end
	end

	// The count is kept after a loss so that software can still read it.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			err_cnt_r <= ERRCNT_ZERO;
		end
		else if (lock_up)
		begin
			err_cnt_r <= ERRCNT_ZERO;
		end
		else if (active && (state_r == ST_LOCKED) && rx_i.lock && rx_i.sym_err
			&& (err_cnt_r != ERRCNT_MAX))
		begin
			err_cnt_r <= err_cnt_r + ERRCNT_ONE;
		end
	end

	// ------------------------------------------------------------------
	// PHY control and status outputs
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ctl_o <= '0;
			test_active_o <= 1'b0;
			lock_o <= 1'b0;
			err_cnt_o <= ERRCNT_ZERO;
		end
		else
		begin
			ctl_o.follower <= active || neg_follower_i;
			ctl_o.send_idle <= active;
			ctl_o.retrain <= retrain_nxt;
			test_active_o <= active;
			lock_o <= lock_r;
			err_cnt_o <= err_cnt_r;
		end
	end

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	always_comb
	begin
		irq_set = IRQ_NONE;
		irq_set[IRQ_LOCK_UP] = lock_up;
		irq_set[IRQ_LOCK_LOST] = lock_lost;
		irq_set[IRQ_CNT_SAT] = cnt_sat;
	end

	// A new event in the same cycle as its clear survives the clear.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_stat_r <= IRQ_NONE;
		end
		else if (reg_wr_i && (reg_addr_i == REG_IRQ_CLR))
		begin
			irq_stat_r <= (irq_stat_r & ~reg_wdata_i[IRQ_W-1:0]) | irq_set;
		end
		else
		begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_en_r <= IRQ_NONE;
		end
		else if (reg_wr_i && (reg_addr_i == REG_IRQ_EN))
		begin
			irq_en_r <= reg_wdata_i[IRQ_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= |(irq_stat_r & irq_en_r);
		end
	end

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	always_comb
	begin
		rdata_nxt = RD_ZERO;
		if (reg_addr_i == REG_ROLE_CTRL)
		begin
			rdata_nxt[BIT_TEST_EN] = test_en_r;
		end
		else if (reg_addr_i == REG_TEST_STAT)
		begin
			rdata_nxt[BIT_LOCK] = lock_r;
			rdata_nxt[ERRCNT_LSB +: ERRCNT_W] = err_cnt_r;
		end
		else if (reg_addr_i == REG_IRQ_STAT)
		begin
			rdata_nxt[IRQ_W-1:0] = irq_stat_r;
		end
		else if (reg_addr_i == REG_IRQ_EN)
		begin
			rdata_nxt[IRQ_W-1:0] = irq_en_r;
		end
	end

	// Read data stand only in the cycle after the strobe and are zero otherwise.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			reg_rdata_o <= RD_ZERO;
		end
		else if (reg_rd_i)
		begin
			reg_rdata_o <= rdata_nxt;
		end
		else
		begin
			reg_rdata_o <= RD_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	logic [RC_W:0] gap_cnt_r;
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			gap_cnt_r <= '0;
		end
		else if ((state_r != ST_ACQ) || ctl_o.retrain)
		begin
			gap_cnt_r <= '0;
		end
		else
		begin
			gap_cnt_r <= gap_cnt_r + 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	mode_hold_a: assert property (test_en_r && !wr_role |=> test_en_r)
		else $error("test enable dropped without a write");
	mode_enter_a: assert property (wr_role && reg_wdata_i[BIT_TEST_EN] |=> active ##1 test_active_o)
		else $error("test mode not entered after enable write");
	role_force_a: assert property (active |=> ctl_o.follower && ctl_o.send_idle)
		else $error("role not follower or not idle in test mode");
	idle_tx_a: assert property (active [*2] |-> ctl_o.send_idle)
		else $error("idle transmission not held in test mode");
	retry_gap_a: assert property (gap_cnt_r <= (RC_W+1)'(GAP_MAX))
		else $error("bring-up retry interval exceeded");
	lock_set_a: assert property (lock_up |=> lock_r && (err_cnt_r == ERRCNT_ZERO) ##1 lock_o)
		else $error("lock set or counter clear missing");
	cnt_clear_a: assert property (lock_up |=> (err_cnt_r == ERRCNT_ZERO))
		else $error("error counter not cleared on lock");
	cnt_inc_a: assert property (active && (state_r == ST_LOCKED) && rx_i.lock && rx_i.sym_err
		&& (err_cnt_r != ERRCNT_MAX) |=> err_cnt_r == $past(err_cnt_r) + ERRCNT_ONE)
		else $error("error counter did not increment");
	lock_clear_a: assert property (lock_lost |=> !lock_r ##1 !lock_o)
		else $error("lock not cleared on loss");
	cnt_sat_a: assert property ((err_cnt_r == ERRCNT_MAX) && !lock_up |=> err_cnt_r == ERRCNT_MAX)
		else $error("error counter wrapped");
	irq_out_a: assert property (|(irq_stat_r & irq_en_r) |=> irq_o)
		else $error("interrupt output missing");

	lock_seen_c: cover property (lock_up ##[1:1000] lock_lost);
	err_seen_c: cover property (lock_up ##[1:20] (rx_i.sym_err && state_r == ST_LOCKED));
	retry_seen_c: cover property (ctl_o.retrain ##[1:1000] ctl_o.retrain);
	sat_seen_c: cover property (cnt_sat);

endmodule // rtm_ctrl

`default_nettype wire

// ### rtm_ctrl_tb_top.sv
// Purpose: Self-checking bench for the receiver test mode controller.
// Assumes: Register reads are sampled at the edge that ends their data cycle.
// Notes: A short retry period keeps the run small.
`timescale 1ns/10ps
`default_nettype none

module rtm_ctrl_tb_top;
	import rtm_pkg::*;
	localparam int RC = 8;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic alt_en = 1'b0;
	logic neg_fol = 1'b0;
	logic want = 1'b0;
	logic err = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] rv;
	logic [ERRCNT_W-1:0] cnt;
	logic act;
	logic lk;
	logic irq;
	rtm_rx_t rx;
	rtm_ctl_t ctl;
	int miscompares = 0;
	int comparisons = 0;
	int seed = 32'h139a;
	int exp_cnt = 0;
	int k = 0;

	initial
	begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	rtm_ctrl #(.RETRY_CYC(RC)) i_rtm_ctrl (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .alt_test_en_i(alt_en), .neg_follower_i(neg_fol),
		.rx_i(rx), .ctl_o(ctl), .test_active_o(act), .lock_o(lk), .err_cnt_o(cnt),
		.irq_o(irq));

	rtm_chan_model i_rtm_chan_model (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.ctl_i(ctl), .want_lock_i(want), .err_i(err), .rx_o(rx));

	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// A spare edge after each write keeps two writes from setting the strobe twice in one step.
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	// Data stand in the cycle after the read edge, so they are taken at its closing edge.
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		@(posedge ref_clk_i);
		d = rdata;
	endtask

	task automatic wait_lk(input logic v);
		for (int i = 0; i < 100 && lk !== v; i++)
			@(posedge ref_clk_i);
		if (lk !== v)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: lock wait timed out", $time);
			wrap_up();
		end
	endtask

	// The model saturates at all ones so that a long burst never reads as small.
	task automatic burst(input int n, input logic all);
		logic e;
		for (int i = 0; i < n; i++)
		begin
			e = all | 1'($random(seed));
			err <= e;
			@(posedge ref_clk_i);
			if (e && exp_cnt < 255)
				exp_cnt++;
		end
		err <= 1'b0;
		cyc(3);
		chk(16'(cnt), 16'(exp_cnt));
		rd_reg(REG_TEST_STAT, rv);
		chk(rv, 16'h2000 | 16'(exp_cnt));
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		cyc(2);
		arst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_reg(REG_ROLE_CTRL, rv);
		chk(rv, RD_ZERO);
		rd_reg(REG_TEST_STAT, rv);
		chk(rv, RD_ZERO);
		rd_reg(5'h1F, rv);
		chk(rv, RD_ZERO);
		wr_reg(REG_IRQ_EN, 16'h0001);
		wr_reg(REG_ROLE_CTRL, 16'h2000);
		cyc(2);
		chk({act, ctl.follower, ctl.send_idle}, 3'b111);
		for (int i = 0; i < 3 * (RC + 1); i++)
		begin
			@(posedge ref_clk_i);
			if (ctl.retrain === 1'b1)
				k++;
		end
		chk(16'(k >= 3 && k <= 4), 16'h0001);
		want <= 1'b1;
		wait_lk(1'b1);
		rd_reg(REG_TEST_STAT, rv);
		chk(rv, 16'h2000);
		chk(irq, 1'b1);
		wr_reg(REG_IRQ_CLR, 16'h0007);
		cyc(2);
		chk(irq, 1'b0);
		burst(40, 1'b0);
		burst(260, 1'b1);
		want <= 1'b0;
		wait_lk(1'b0);
		rd_reg(REG_TEST_STAT, rv);
		chk(rv, 16'h00FF);
		chk(act, 1'b1);
		rd_reg(REG_IRQ_STAT, rv);
		chk(rv, 16'h0006);
		chk(irq, 1'b0);
		wr_reg(REG_IRQ_EN, 16'h0002);
		cyc(2);
		chk(irq, 1'b1);
		want <= 1'b1;
		wait_lk(1'b1);
		exp_cnt = 0;
		rd_reg(REG_TEST_STAT, rv);
		chk(rv, 16'h2000);
		wr_reg(REG_ROLE_CTRL, RD_ZERO);
		cyc(2);
		chk({act, ctl.send_idle}, 2'b00);
		neg_fol <= 1'($random(seed));
		cyc(3);
		chk(ctl.follower, neg_fol);
		alt_en <= 1'b1;
		cyc(3);
		chk(act, 1'b1);
		alt_en <= 1'b0;
		wr_reg(REG_ROLE_CTRL, 16'h2000);
		cyc(3);
		arst_n_i <= 1'b0;
		cyc(2);
		arst_n_i <= 1'b1;
		cyc(1);
		rd_reg(REG_ROLE_CTRL, rv);
		chk(rv, RD_ZERO);
		chk({act, lk, cnt}, 10'h000);
		wrap_up();
	end
endmodule // rtm_ctrl_tb_top

`default_nettype wire

// ### rtm_pkg.sv
// Purpose: Shared constants and types for the receiver test mode controller.
// Assumes: 100 MHz symbol clock; registers addressed by their management index.
// Notes: Interrupt register offsets sit in an otherwise unused part of the map.
`default_nettype none

package rtm_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] REG_ROLE_CTRL = 5'h09;
	localparam logic [ADDR_W-1:0] REG_TEST_STAT = 5'h0A;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h18;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 5'h19;
	localparam logic [ADDR_W-1:0] REG_IRQ_EN = 5'h1A;
	localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;

	// ------------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------------
	localparam int BIT_TEST_EN = 13;
	localparam int BIT_LOCK = 13;
	localparam int ERRCNT_W = 8;
	localparam int ERRCNT_LSB = 0;
	localparam logic [ERRCNT_W-1:0] ERRCNT_ZERO = 8'h00;
	localparam logic [ERRCNT_W-1:0] ERRCNT_ONE = 8'h01;
	localparam logic [ERRCNT_W-1:0] ERRCNT_MAX = 8'hFF;

	localparam int IRQ_W = 3;
	localparam int IRQ_LOCK_UP = 0;
	localparam int IRQ_LOCK_LOST = 1;
	localparam int IRQ_CNT_SAT = 2;
	localparam logic [IRQ_W-1:0] IRQ_NONE = 3'h0;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int RETRY_TIME_US = 10;
	localparam int RETRY_CYCLES = RETRY_TIME_US * CLK_MHZ;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {ST_OFF, ST_ACQ, ST_LOCKED} rtm_state_t;

	typedef struct packed {
		logic lock;
		logic sym_err;
	} rtm_rx_t;

	typedef struct packed {
		logic follower;
		logic send_idle;
		logic retrain;
	} rtm_ctl_t;

endpackage

`default_nettype wire
